// *** src/bert_pkg.sv ***
// Shared constants, register map and carrier types of the bit error rate tester
package bert_pkg;
    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned SECOND_NS = 1000000000;
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;
    localparam int unsigned PRBS_LEN = 9;
    localparam int unsigned PRBS_TAP = 5;
    localparam int unsigned ERR_MAX = 64000;
    localparam int unsigned SYNC_BITS = 9;
    localparam int unsigned PORT_W = 3;
    localparam logic [PRBS_LEN-1:0] PRBS_SEED = 9'h1ff;

    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] STATUS_OFF = 8'h04;
    localparam logic [7:0] TIME_OFF = 8'h08;
    localparam logic [7:0] ERRCNT_OFF = 8'h0c;
    localparam logic [7:0] ERRSEC_OFF = 8'h10;

    localparam int unsigned CTRL_START_BIT = 0;
    localparam int unsigned CTRL_ABORT_BIT = 1;
    localparam int unsigned CTRL_CLEAR_BIT = 2;
    localparam int unsigned CTRL_AGGR_BIT = 3;
    localparam int unsigned CTRL_PORT_LSB = 4;

    localparam int unsigned ST_ACTIVE_BIT = 0;
    localparam int unsigned ST_FINAL_BIT = 1;
    localparam int unsigned ST_MAX_BIT = 2;
    localparam int unsigned ST_SYNC_BIT = 3;
    localparam int unsigned ST_REJECT_BIT = 4;

    typedef enum logic [1:0] {
        ROLE_CONTROL,
        ROLE_TRIBUTARY
    } role_t;

    typedef struct packed {
        logic bridge_mode;
        logic multipoint;
        logic tributary;
        logic nondisruptive;
    } unit_cfg_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;
endpackage

// *** src/bert_fifo2.sv ***
// Two-entry valid/ready buffer for received line bits
module bert_fifo2 #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;
        logic [1:0] cnt;
    } fifo_state_t;
    fifo_state_t s_reg, s_next;
    logic push, pop;

    if (WIDTH < 1) begin : g_bad_width
        $error("WIDTH must be at least 1");
    end

    assign in_ready = (s_reg.cnt != 2'd2);
    assign out_valid = (s_reg.cnt != 2'd0);
    assign out_data = s_reg.mem[0];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        s_next = s_reg;
        if (pop) begin
            s_next.mem[0] = s_reg.mem[1];
        end
        if (push) begin
            if (s_reg.cnt == 2'd0 || (s_reg.cnt == 2'd1 && pop)) begin
                s_next.mem[0] = in_data;
            end else begin
                s_next.mem[1] = in_data;
            end
        end
        s_next.cnt = s_reg.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end
endmodule

// *** src/bert_prbs.sv ***
// Nine-stage pattern register used as generator and as checker reference
module bert_prbs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic load,
    input wire logic [bert_pkg::PRBS_LEN-1:0] load_val,
    input wire logic step,
    output logic [bert_pkg::PRBS_LEN-1:0] state,
    output logic bit_out
);
    import bert_pkg::*;
    typedef struct packed {
        logic [PRBS_LEN-1:0] lfsr;
    } prbs_state_t;
    prbs_state_t s_reg, s_next;

    assign state = s_reg.lfsr;
    assign bit_out = s_reg.lfsr[PRBS_LEN-1] ^ s_reg.lfsr[PRBS_TAP-1];

    always_comb begin
        s_next = s_reg;
        if (load) begin
            s_next.lfsr = load_val;
        end else if (step) begin
            s_next.lfsr = {s_reg.lfsr[PRBS_LEN-2:0], bit_out};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg.lfsr <= PRBS_SEED;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end
endmodule

// *** src/bert_core.sv ***
// Bit error rate tester: pattern generator, checker, counters and APB registers
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
module bert_core #(
    parameter int unsigned SEC_CYCLES = bert_pkg::SECOND_CYCLES,
    parameter int unsigned NUM_PORTS = 6
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire bert_pkg::unit_cfg_t unit_cfg,
    input wire logic line_bit_en,
    input wire logic rx_bit,
    output logic tx_bit,
    output logic tx_valid,
    output logic aggr_sel,
    output logic [bert_pkg::PORT_W-1:0] port_sel,
    output logic secondary_off,
    output logic basic_loop_path,
    output logic test_active
);
    import bert_pkg::*;

    // The port field cannot name more ports, and the divider needs at least two counts
    if (NUM_PORTS < 1 || NUM_PORTS > (1 << PORT_W)) begin : g_bad_ports
        $error("NUM_PORTS out of range");
    end
    if (SEC_CYCLES < 2) begin : g_bad_second
        $error("SEC_CYCLES too small");
    end

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_FINAL
    } test_state_t;

    typedef struct packed {
        test_state_t fsm;
        logic aggr;
        logic [PORT_W-1:0] port;
        logic [31:0] sec_div;
        logic [31:0] elapsed;
        logic [15:0] err_cnt;
        logic [15:0] err_secs;
        logic err_this_sec;
        logic [3:0] sync_cnt;
        logic in_sync;
        logic rejected;
        logic [PRBS_LEN-1:0] rx_shift;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic tx_bit;
        logic tx_valid;
        logic secondary_off;
        logic active;
        logic [1:0] rx_sync;
        logic [1:0] en_sync;
        logic en_last;
    } core_state_t;
    core_state_t s_reg, s_next;

    logic gen_step, chk_load, chk_step, gen_bit, chk_bit;
    logic [PRBS_LEN-1:0] chk_state;
    logic buf_out_valid, buf_out_ready, buf_bit;
    logic line_tick, access, wr, start_ok, port_ok;
    logic [PRBS_LEN-1:0] shift_now;

    function automatic logic [15:0] sat_inc(input logic [15:0] v, input logic [15:0] lim);
        return (v >= lim) ? lim : v + 16'h0001;
    endfunction

    // Line strobe crosses from the pin domain; only the second stage is read
    assign line_tick = s_reg.en_sync[1] && !s_reg.en_last;
    assign gen_step = line_tick && (s_reg.fsm == ST_RUN);
    assign buf_out_ready = (s_reg.fsm == ST_RUN);
    assign shift_now = {s_reg.rx_shift[PRBS_LEN-2:0], buf_bit};
    // Load the reference from received bits until it tracks, so a remote loop of
    // any delay or a remote generator of any phase is acquired
    assign chk_load = buf_out_valid && buf_out_ready && !s_reg.in_sync;
    assign chk_step = buf_out_valid && buf_out_ready && s_reg.in_sync;
    assign access = psel && penable;
    assign wr = access && pwrite && !s_reg.pready;
    assign start_ok = !unit_cfg.bridge_mode && !(unit_cfg.tributary && unit_cfg.multipoint);
    // One spare bit so that a full set of eight ports still compares correctly
    assign port_ok = {1'b0, pwdata[CTRL_PORT_LSB +: PORT_W]} < (PORT_W + 1)'(NUM_PORTS);

    bert_prbs u_gen (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .load(1'b0),
        .load_val(PRBS_SEED),
        .step(gen_step),
        .state(),
        .bit_out(gen_bit)
    );

    bert_prbs u_chk (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .load(chk_load),
        .load_val(shift_now),
        .step(chk_step),
        .state(chk_state),
        .bit_out(chk_bit)
    );

    // A stall while idle holds back the first two received bits and drops the later ones
    bert_fifo2 #(.WIDTH(1)) u_buf (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .in_valid(line_tick),
        .in_ready(),
        .in_data(s_reg.rx_sync[1]),
        .out_valid(buf_out_valid),
        .out_ready(buf_out_ready),
        .out_data(buf_bit)
    );

    always_comb begin
        s_next = s_reg;
        s_next.rx_sync = {s_reg.rx_sync[0], rx_bit};
        s_next.en_sync = {s_reg.en_sync[0], line_bit_en};
        s_next.en_last = s_reg.en_sync[1];
        s_next.tx_valid = gen_step;
        if (gen_step) begin
            s_next.tx_bit = gen_bit;
        end
        // Compare received bits against the reference
        if (buf_out_valid && buf_out_ready) begin
            s_next.rx_shift = shift_now;
            if (!s_reg.in_sync) begin
                // A window with a stale or repeated bit after a restart predicts wrongly,
                // so lock only after a run of correct predictions
                if (buf_bit != chk_bit || chk_state == '0) begin
                    s_next.sync_cnt = '0;
                end else if (s_reg.sync_cnt == 4'(SYNC_BITS - 1)) begin
                    s_next.in_sync = 1'b1;
                end else begin
                    s_next.sync_cnt = s_reg.sync_cnt + 4'h1;
                end
            end else if (buf_bit != chk_bit) begin
                s_next.err_cnt = sat_inc(s_reg.err_cnt, 16'(ERR_MAX));
                s_next.err_this_sec = 1'b1;
            end
        end
        if (s_reg.fsm == ST_RUN) begin
            if (s_reg.sec_div == SEC_CYCLES - 1) begin
                s_next.sec_div = '0;
                s_next.elapsed = s_reg.elapsed + 32'h1;
                // An error in the closing cycle still belongs to this second
                if (s_next.err_this_sec) begin
                    s_next.err_secs = sat_inc(s_reg.err_secs, 16'hffff);
                end
                s_next.err_this_sec = 1'b0;
            end else begin
                s_next.sec_div = s_reg.sec_div + 32'h1;
            end
        end
        // APB: one wait state, answer on second access cycle
        s_next.pready = access && !s_reg.pready;
        s_next.pslverr = 1'b0;
        if (access && !s_reg.pready) begin
            s_next.prdata = '0;
            unique case (paddr)
                CTRL_OFF: s_next.prdata = 32'({s_reg.port, s_reg.aggr, 3'b000});
                STATUS_OFF: s_next.prdata = 32'({s_reg.rejected, s_reg.in_sync,
                    (s_reg.err_cnt == 16'(ERR_MAX)), (s_reg.fsm == ST_FINAL),
                    (s_reg.fsm == ST_RUN)});
                TIME_OFF: s_next.prdata = s_reg.elapsed;
                ERRCNT_OFF: s_next.prdata = {16'h0000, s_reg.err_cnt};
                ERRSEC_OFF: s_next.prdata = {16'h0000, s_reg.err_secs};
                default: s_next.pslverr = 1'b1;
            endcase
        end
        if (wr && paddr == CTRL_OFF) begin
            if (s_reg.fsm != ST_RUN) begin
                s_next.aggr = pwdata[CTRL_AGGR_BIT];
                s_next.port = pwdata[CTRL_PORT_LSB +: PORT_W];
            end
            if (pwdata[CTRL_CLEAR_BIT]) begin
                s_next.elapsed = '0;
                s_next.err_cnt = '0;
                s_next.err_secs = '0;
                s_next.sec_div = '0;
                s_next.err_this_sec = 1'b0;
                s_next.in_sync = 1'b0;
                s_next.sync_cnt = '0;
            end
            if (pwdata[CTRL_ABORT_BIT] && s_reg.fsm == ST_RUN) begin
                s_next.fsm = ST_FINAL;
            end else if (pwdata[CTRL_START_BIT] && s_reg.fsm != ST_RUN) begin
                if (start_ok && port_ok) begin
                    s_next.fsm = ST_RUN;
                    s_next.rejected = 1'b0;
                    s_next.elapsed = '0;
                    s_next.err_cnt = '0;
                    s_next.err_secs = '0;
                    s_next.sec_div = '0;
                    s_next.err_this_sec = 1'b0;
                    s_next.in_sync = 1'b0;
                    s_next.sync_cnt = '0;
                end else begin
                    s_next.rejected = 1'b1;
                end
            end
        end
        // Secondary channel off while aggregate test runs
        s_next.secondary_off = (s_next.fsm == ST_RUN) && s_next.aggr;
        s_next.active = (s_next.fsm == ST_RUN);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
            s_reg.fsm <= ST_IDLE;
            s_reg.aggr <= 1'b1;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign prdata = s_reg.prdata;
    assign pready = s_reg.pready;
    assign pslverr = s_reg.pslverr;
    assign tx_bit = s_reg.tx_bit;
    assign tx_valid = s_reg.tx_valid;
    assign aggr_sel = s_reg.aggr;
    assign port_sel = s_reg.port;
    assign secondary_off = s_reg.secondary_off;
    assign basic_loop_path = s_reg.secondary_off;
    assign test_active = s_reg.active;

    a_abort_final: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && wr && paddr == CTRL_OFF && pwdata[CTRL_ABORT_BIT] && s_reg.fsm == ST_RUN)
        |=> (s_reg.fsm == ST_FINAL))
        else $error("abort did not end test");
    a_bridge_refuse: assert property (@(posedge pclk) disable iff (!presetn)
        (unit_cfg.bridge_mode && s_reg.fsm != ST_RUN) |=> (s_reg.fsm != ST_RUN))
        else $error("test started in bridge mode");
    a_trib_multi: assert property (@(posedge pclk) disable iff (!presetn)
        (unit_cfg.tributary && unit_cfg.multipoint && s_reg.fsm != ST_RUN)
        |=> (s_reg.fsm != ST_RUN))
        else $error("tributary started in multipoint");
    a_err_sat: assert property (@(posedge pclk) disable iff (!presetn)
        s_reg.err_cnt <= 16'(ERR_MAX))
        else $error("error count above maximum");
    a_err_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && s_reg.err_cnt == 16'(ERR_MAX) && !(wr && pwdata[CTRL_CLEAR_BIT])
        && !(wr && pwdata[CTRL_START_BIT])) |=> (s_reg.err_cnt == 16'(ERR_MAX)))
        else $error("saturated count moved");
    a_clear_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && wr && paddr == CTRL_OFF && pwdata[CTRL_CLEAR_BIT])
        |=> (s_reg.elapsed == 0 && s_reg.err_cnt == 0 && s_reg.err_secs == 0))
        else $error("clear left results");
    a_tx_run: assert property (@(posedge pclk) disable iff (!presetn)
        s_reg.tx_valid |-> $past(s_reg.fsm == ST_RUN))
        else $error("pattern sent while idle");
    a_sec_aggr: assert property (@(posedge pclk) disable iff (!presetn)
        (s_reg.fsm == ST_RUN && s_reg.aggr) |=> secondary_off || !ce
        || s_reg.fsm != ST_RUN)
        else $error("secondary channel not suspended");
    a_no_restart: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && s_reg.fsm == ST_RUN && wr && pwdata[CTRL_START_BIT] && !pwdata[CTRL_ABORT_BIT]
        && !pwdata[CTRL_CLEAR_BIT]) |=> $stable(s_reg.elapsed) || s_reg.elapsed == 1
        || $past(s_reg.sec_div) == SEC_CYCLES - 1)
        else $error("start accepted while running");
    a_start_control: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && wr && paddr == CTRL_OFF && pwdata[CTRL_START_BIT] && !pwdata[CTRL_ABORT_BIT]
        && s_reg.fsm != ST_RUN && !unit_cfg.bridge_mode && !unit_cfg.tributary
        && pwdata[CTRL_PORT_LSB +: PORT_W] == '0) |=> (s_reg.fsm == ST_RUN))
        else $error("control unit refused a start");
    a_bridge_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && wr && paddr == CTRL_OFF && pwdata[CTRL_START_BIT] && s_reg.fsm != ST_RUN
        && unit_cfg.bridge_mode) |=> s_reg.rejected)
        else $error("bridge start not flagged");
    a_sel_frozen: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && s_reg.fsm == ST_RUN) |=> ($stable(s_reg.aggr) && $stable(s_reg.port)))
        else $error("path changed while running");
    a_elapsed_idle: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && s_reg.fsm != ST_RUN)
        |=> (s_reg.elapsed == $past(s_reg.elapsed) || s_reg.elapsed == 32'h0))
        else $error("timer moved while stopped");
    a_err_step: assert property (@(posedge pclk) disable iff (!presetn)
        s_reg.err_cnt == 16'h0000 || s_reg.err_cnt <= $past(s_reg.err_cnt) + 16'h0001)
        else $error("error count jumped");
    a_secs_edge: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && s_reg.sec_div != SEC_CYCLES - 1)
        |=> (s_reg.err_secs == $past(s_reg.err_secs) || s_reg.err_secs == 16'h0000))
        else $error("errored seconds moved inside a second");
    a_sync_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && !s_reg.in_sync)
        |=> (s_reg.err_cnt == $past(s_reg.err_cnt) || s_reg.err_cnt == 16'h0000))
        else $error("errors counted before sync");
    a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && s_reg.pready) |=> !s_reg.pready)
        else $error("ready stood longer than one cycle");
endmodule

// *** sim/bert_remote_model.sv ***
// Far-end unit model: digital loopback or its own pattern test, with error injection
module bert_remote_model
    import bert_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tx_bit,
    input wire logic tx_valid,
    input wire logic own_mode,
    input wire logic flip,
    input wire logic chk_clear,
    output logic rx_bit,
    output int unsigned err_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [PRBS_LEN-1:0] gen;
    logic [PRBS_LEN-1:0] hist;
    int unsigned seen;

    // Only reacts to bits the unit really sends; no bit is invented between pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gen <= PRBS_SEED;
            hist <= '0;
            seen <= 0;
            err_cnt <= 0;
            rx_bit <= 1'b0;
        end else begin
            if (chk_clear) begin
                seen <= 0;
                err_cnt <= 0;
            end else if (tx_valid) begin
                // Each bit after the first nine seen must follow the nine-stage recurrence
                if (seen >= PRBS_LEN && tx_bit !== (hist[PRBS_LEN-1] ^ hist[PRBS_TAP-1])) begin
                    err_cnt <= err_cnt + 1;
                end
                if (seen < PRBS_LEN) begin
                    seen <= seen + 1;
                end
            end
            if (tx_valid) begin
                hist <= {hist[PRBS_LEN-2:0], tx_bit};
                gen <= {gen[PRBS_LEN-2:0], gen[PRBS_LEN-1] ^ gen[PRBS_TAP-1]};
                // Loop back or send own pattern; flip only when a scenario asks
                rx_bit <= (own_mode ? (gen[PRBS_LEN-1] ^ gen[PRBS_TAP-1]) : tx_bit) ^ flip;
            end
        end
    end
endmodule

// *** sim/line_bit_error_rate_tester_bench.sv ***
// Self-checking bench of the bit error rate tester with a far-end model
module line_bit_error_rate_tester_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import bert_pkg::*;
    localparam int unsigned SEC_CYC = 600;
    localparam int unsigned BIT_CYC = 6;
    // Case entries: bridge, multipoint, tributary, nondisruptive, aggregate
    localparam logic [4:0] CASES [6] = '{5'b10001, 5'b01101, 5'b00000, 5'b01001, 5'b00100,
        5'b00011};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, rx_bit, tx_bit, tx_valid, aggr_sel, secondary_off;
    logic basic_loop_path, test_active;
    logic [PORT_W-1:0] port_sel;
    unit_cfg_t unit_cfg = '0;
    logic line_bit_en = 1'b0;
    logic own_mode = 1'b0;
    logic flip = 1'b0;
    logic chk_clear = 1'b0;
    logic ce = 1'b1;
    int unsigned remote_err;
    int unsigned bit_div = 0;
    int n_mismatch = 0;
    int n_checks = 0;
    logic [31:0] rnd = 32'h608b9d07;

    always #4 pclk = ~pclk;

    // Line bit strobe, one bit every BIT_CYC cycles
    always @(posedge pclk) begin
        bit_div <= (bit_div == BIT_CYC - 1) ? 0 : bit_div + 1;
        line_bit_en <= (bit_div < 3);
    end

    bert_core #(.SEC_CYCLES(SEC_CYC), .NUM_PORTS(6)) bert_core_inst (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .unit_cfg(unit_cfg), .line_bit_en(line_bit_en), .rx_bit(rx_bit),
        .tx_bit(tx_bit), .tx_valid(tx_valid), .aggr_sel(aggr_sel), .port_sel(port_sel),
        .secondary_off(secondary_off), .basic_loop_path(basic_loop_path),
        .test_active(test_active));

    bert_remote_model bert_remote_model_inst (
        .pclk(pclk), .presetn(presetn), .tx_bit(tx_bit), .tx_valid(tx_valid),
        .own_mode(own_mode), .flip(flip), .chk_clear(chk_clear), .rx_bit(rx_bit),
        .err_cnt(remote_err));

    function automatic logic [31:0] lfsr_next(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [31:0] ctrl(logic s, logic a, logic c, logic g, logic [2:0] p);
        logic [31:0] w;
        w = 32'h0;
        w[CTRL_START_BIT] = s;
        w[CTRL_ABORT_BIT] = a;
        w[CTRL_CLEAR_BIT] = c;
        w[CTRL_AGGR_BIT] = g;
        w[CTRL_PORT_LSB +: PORT_W] = p;
        return w;
    endfunction

    // A start is taken only outside bridge mode, never by a multipoint tributary
    function automatic logic start_ok(logic [4:0] c, logic [2:0] p);
        return !c[4] && !(c[3] && c[2]) && (p < 3'h6);
    endfunction

    task automatic summarize();
        $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; entered just after a rising edge, holds until pready is sampled
    task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                            output logic [31:0] rd, output logic err);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_mismatch++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] d;
        logic e;
        apb_xfer(1'b1, a, wd, d, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic e;
        apb_xfer(1'b0, a, 32'h0, d, e);
    endtask

    // Returns just after the elapsed timer has moved on
    task automatic wait_second();
        logic [31:0] t0, t;
        int n;
        rd(TIME_OFF, t0);
        n = 0;
        do begin
            rd(TIME_OFF, t);
            n++;
        end while (t === t0 && n < 1000);
        if (n >= 1000) begin
            n_mismatch++;
            summarize();
        end
    endtask

    task automatic remote_clear();
        chk_clear <= 1'b1;
        @(posedge pclk);
        chk_clear <= 1'b0;
    endtask

    initial begin
        repeat (100000) @(posedge pclk);
        n_mismatch++;
        summarize();
    end

    initial begin
        logic [31:0] d, t1;
        logic e, ok;
        logic [4:0] c;
        logic [2:0] p;
        int total, b;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(CTRL_OFF, d);
        check("ctrl reset", d, ctrl(0, 0, 0, 1, 3'h0));
        apb_xfer(1'b0, 8'h14, 32'h0, d, e);
        check("unmapped error", 32'(e), 32'h1);
        for (int i = 0; i < 6; i++) begin
            c = CASES[i];
            rnd = lfsr_next(rnd);
            p = (i == 2) ? 3'(6 + rnd[0]) : 3'(rnd % 6);
            ok = start_ok(c, p);
            unit_cfg <= unit_cfg_t'(c[4:1]);
            @(posedge pclk);
            wr(CTRL_OFF, ctrl(1, 0, 0, c[0], p));
            rd(STATUS_OFF, d);
            check("start taken", 32'(d[ST_ACTIVE_BIT]), 32'(ok));
            if (!ok) begin
                check("start refused", 32'(d[ST_REJECT_BIT]), 32'h1);
            end else begin
                check("secondary off", 32'(secondary_off), 32'(c[0]));
                check("loop path", 32'(basic_loop_path), 32'(c[0]));
                check("aggr sel", 32'(aggr_sel), 32'(c[0]));
                if (!c[0]) check("port sel", 32'(port_sel), 32'(p));
                wr(CTRL_OFF, ctrl(1, 0, 0, !c[0], p ^ 3'h1));
                check("second start aggr", 32'(aggr_sel), 32'(c[0]));
                if (!c[0]) check("second start port", 32'(port_sel), 32'(p));
                check("still active", 32'(test_active), 32'h1);
                wr(CTRL_OFF, ctrl(0, 1, 0, 0, 3'h0));
                rd(STATUS_OFF, d);
                check("final status", 32'(d[1:0]), 32'h2);
            end
        end
        unit_cfg <= '0;
        @(posedge pclk);
        wr(CTRL_OFF, ctrl(1, 0, 0, 1, 3'h0));
        remote_clear();
        wait_second();
        wait_second();
        // Bursts start right after a second boundary so each lands in one second
        total = 0;
        for (int k = 0; k < 3; k++) begin
            wait_second();
            rnd = lfsr_next(rnd);
            b = 1 + int'(rnd % 4);
            total += b;
            flip <= 1'b1;
            repeat (b * BIT_CYC) @(posedge pclk);
            flip <= 1'b0;
            @(posedge pclk);
        end
        wait_second();
        rd(ERRCNT_OFF, d);
        check("bit errors", d, 32'(total));
        rd(ERRSEC_OFF, d);
        check("errored seconds", d, 32'h3);
        check("remote pattern errors", 32'(remote_err), 32'h0);
        wait_second();
        rd(TIME_OFF, t1);
        repeat (3 * SEC_CYC) @(posedge pclk);
        rd(TIME_OFF, d);
        check("elapsed seconds", d, t1 + 32'h3);
        wr(CTRL_OFF, ctrl(0, 0, 1, 1, 3'h0));
        rd(TIME_OFF, d);
        check("time cleared", d, 32'h0);
        rd(ERRCNT_OFF, d);
        check("errors cleared", d, 32'h0);
        rd(ERRSEC_OFF, d);
        check("err secs cleared", d, 32'h0);
        own_mode <= 1'b1;
        repeat (10 * BIT_CYC) @(posedge pclk);
        wr(CTRL_OFF, ctrl(0, 0, 1, 1, 3'h0));
        repeat (2 * SEC_CYC) @(posedge pclk);
        rd(ERRCNT_OFF, d);
        check("remote own pattern", d, 32'h0);
        rd(STATUS_OFF, d);
        check("in sync", 32'(d[ST_SYNC_BIT]), 32'h1);
        check("active", 32'(d[ST_ACTIVE_BIT]), 32'h1);
        // Timer must not advance while the clock enable is low
        wait_second();
        rd(TIME_OFF, t1);
        ce <= 1'b0;
        repeat (2 * SEC_CYC) @(posedge pclk);
        ce <= 1'b1;
        rd(TIME_OFF, d);
        check("enable freeze", d, t1);
        wr(CTRL_OFF, ctrl(0, 1, 0, 1, 3'h0));
        rd(TIME_OFF, t1);
        repeat (2 * SEC_CYC) @(posedge pclk);
        rd(TIME_OFF, d);
        check("time frozen", d, t1);
        check("inactive", 32'(test_active), 32'h0);
        summarize();
    end
endmodule
